/* rtl/dcpdc_map.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 8-bit register addresses and data
// Notes: included by bare name
`ifndef DCPDC_MAP_SVH
`define DCPDC_MAP_SVH

`define DCPDC_OFF_DETECT 8'h24
`define DCPDC_OFF_DUTY 8'h25
`define DCPDC_OFF_MODE 8'h26
`define DCPDC_OFF_TARGET 8'h27
`define DCPDC_OFF_DELAY 8'h28
`define DCPDC_OFF_POLICY 8'h29
`define DCPDC_OFF_STATUS 8'h2A

`define DCPDC_BIT_BOOST 5
`define DCPDC_BIT_AUTO 4
`define DCPDC_BIT_DUTY 0
`define DCPDC_BIT_SLOPE 6
`define DCPDC_MODE_HI 5
`define DCPDC_MODE_LO 4
`define DCPDC_BIT_READ 3
`define DCPDC_GAIN_HI 2
`define DCPDC_GAIN_LO 1
`define DCPDC_BIT_ENABLE 0
`define DCPDC_BIT_DLSB 7
`define DCPDC_DIR_HI 6
`define DCPDC_DIR_LO 5
`define DCPDC_PHASE_HI 4
`define DCPDC_BIT_TOL 7
`define DCPDC_BIT_RETRY 6
`define DCPDC_BIT_CONTINUE_OR_RESET 5
`define DCPDC_GUARD_HI 4
`define DCPDC_BIT_LOST 1
`define DCPDC_BIT_LOCKED 0

`define DCPDC_RST_DETECT 8'h00
`define DCPDC_RST_DUTY 8'h00
`define DCPDC_RST_MODE 8'h42
`define DCPDC_RST_TARGET 8'h00
`define DCPDC_RST_DELAY 8'h00
`define DCPDC_RST_POLICY 8'h0B

`define DCPDC_MODE_SEARCH_TRACK 2'h0
`define DCPDC_MODE_SEARCH_ONLY 2'h1
`define DCPDC_MODE_TRACK_ONLY 2'h2
`define DCPDC_DIR_DOWN 2'h0
`define DCPDC_DIR_UP 2'h1
`define DCPDC_DIR_DOWN_UP 2'h2

`define DCPDC_DELAY_MAX 432
`define DCPDC_PHASE_MAX 16
`define DCPDC_LOOSE_TOL 2
`define DCPDC_SETTLE_CYCLES 16

`endif

/* rtl/dcpdc_pkg.sv */
// Purpose: types shared by the phase delay controller
// Assumes: nothing beyond the map header
// Notes: constants live in dcpdc_map.svh
package dcpdc_pkg;
  typedef enum logic [2:0] {
    DCPDC_IDLE,
    DCPDC_SEARCH,
    DCPDC_TRACK,
    DCPDC_HOLD,
    DCPDC_STOP
  } dcpdc_state_t;
endpackage

/* rtl/dcpdc_top.sv */
// Purpose: phase alignment controller driving a 9-bit delay line, with its registers
// Assumes: phase detector outputs are synchronous to mclk_in
// Notes: read data is registered and valid the cycle after the read strobe
`timescale 1ns/1ns
`include "dcpdc_map.svh"

module dcpdc_top #(
  parameter int DELAY_MAX = `DCPDC_DELAY_MAX,
  parameter int SETTLE_CYCLES = `DCPDC_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // phase detector
  input wire logic [4:0] phase_in,
  input wire logic slope_in,
  // delay line and controls
  output logic [8:0] delay_line_out,
  output logic detector_bias_boost_out,
  output logic detector_auto_enable_out,
  output logic duty_cycle_auto_enable_out
);

  if (DELAY_MAX < 1 || DELAY_MAX > 511)
  begin : g_chk_max
    $error("DELAY_MAX must fit the 9-bit delay line");
  end
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
  begin : g_chk_settle
    $error("SETTLE_CYCLES must be 1 to 255");
  end

  localparam logic [8:0] MAX9 = 9'(DELAY_MAX);
  localparam logic [7:0] SETTLE8 = 8'(SETTLE_CYCLES - 1);

  logic [7:0] detect_reg, duty_reg, mode_reg, target_reg, delay_hi_reg, policy_reg;
  dcpdc_pkg::dcpdc_state_t state_reg;
  logic [8:0] delay_reg, delay_next;
  logic [8:0] locked_val_reg;
  logic [7:0] settle_reg;
  logic pass_reg, leg_up_reg;
  logic locked_reg, lost_reg;

  wire [8:0] setting = {delay_hi_reg, target_reg[`DCPDC_BIT_DLSB]};
  wire [8:0] setting_clamped = (setting > MAX9) ? MAX9 : setting;
  wire [1:0] mode = mode_reg[`DCPDC_MODE_HI:`DCPDC_MODE_LO];
  wire [1:0] dir = target_reg[`DCPDC_DIR_HI:`DCPDC_DIR_LO];
  wire [1:0] gain = mode_reg[`DCPDC_GAIN_HI:`DCPDC_GAIN_LO];
  wire [4:0] target = (target_reg[`DCPDC_PHASE_HI:0] > 5'(`DCPDC_PHASE_MAX)) ?
    5'(`DCPDC_PHASE_MAX) : target_reg[`DCPDC_PHASE_HI:0];
  wire [4:0] guard = policy_reg[`DCPDC_GUARD_HI:0];
  wire slope_pos = mode_reg[`DCPDC_BIT_SLOPE];
  // detector and duty functions must be on or the loop would chase garbage
  wire run = mode_reg[`DCPDC_BIT_ENABLE] & detect_reg[`DCPDC_BIT_BOOST] &
    detect_reg[`DCPDC_BIT_AUTO] & duty_reg[`DCPDC_BIT_DUTY];
  wire tick = (settle_reg == 8'h00);

  // tolerance check shared by search and track
  function automatic logic phase_ok(input logic [4:0] ph, input logic [4:0] tg,
                                    input logic exact);
    logic [4:0] d;
    d = (ph > tg) ? (ph - tg) : (tg - ph);
    phase_ok = exact ? (d == 5'h00) : (d <= 5'(`DCPDC_LOOSE_TOL));
  endfunction

  function automatic logic [8:0] lo_bound(input logic full, input logic [4:0] g);
    lo_bound = full ? 9'h000 : {4'h0, g};
  endfunction

  function automatic logic [8:0] hi_bound(input logic full, input logic [4:0] g,
                                          input logic [8:0] mx);
    hi_bound = full ? mx : (mx - {4'h0, g});
  endfunction

  wire match = phase_ok(phase_in, target, policy_reg[`DCPDC_BIT_TOL]) &&
    (slope_in == slope_pos);
  wire [8:0] lo = lo_bound(pass_reg, guard);
  wire [8:0] hi = hi_bound(pass_reg, guard, MAX9);
  wire [8:0] step = 9'h001 << gain;
  wire first_up = (dir == `DCPDC_DIR_UP);

  // register writes
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      detect_reg <= `DCPDC_RST_DETECT;
      duty_reg <= `DCPDC_RST_DUTY;
      mode_reg <= `DCPDC_RST_MODE;
      target_reg <= `DCPDC_RST_TARGET;
      delay_hi_reg <= `DCPDC_RST_DELAY;
      policy_reg <= `DCPDC_RST_POLICY;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `DCPDC_OFF_DETECT: detect_reg <= reg_wdata_in & 8'h30;
        `DCPDC_OFF_DUTY: duty_reg <= reg_wdata_in & 8'h01;
        `DCPDC_OFF_MODE: mode_reg <= reg_wdata_in & 8'h7F;
        `DCPDC_OFF_TARGET: target_reg <= reg_wdata_in;
        `DCPDC_OFF_DELAY: delay_hi_reg <= reg_wdata_in;
        `DCPDC_OFF_POLICY: policy_reg <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // register reads
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `DCPDC_OFF_DETECT: reg_rdata_out <= detect_reg;
        `DCPDC_OFF_DUTY: reg_rdata_out <= duty_reg;
        `DCPDC_OFF_MODE: reg_rdata_out <= mode_reg;
        `DCPDC_OFF_TARGET: reg_rdata_out <= target_reg;
        `DCPDC_OFF_DELAY:
          if (!mode_reg[`DCPDC_BIT_READ])
            reg_rdata_out <= 8'h00;
          else if (mode_reg[`DCPDC_BIT_ENABLE])
            reg_rdata_out <= locked_val_reg[8:1];
          else
            reg_rdata_out <= delay_hi_reg;
        `DCPDC_OFF_POLICY: reg_rdata_out <= policy_reg;
        `DCPDC_OFF_STATUS: reg_rdata_out <= {6'h00, lost_reg, locked_reg};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // detector settle pacing: each decision waits for the detector to respond
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || !run || tick)
      settle_reg <= SETTLE8;
    else
      settle_reg <= settle_reg - 8'h01;
  end

  // next delay while tracking, saturating at 0 and DELAY_MAX
  always_comb
  begin
    delay_next = delay_reg;
    if (!phase_ok(phase_in, target, 1'b1))
    begin
      if ((phase_in < target) == slope_pos)
        delay_next = (delay_reg > MAX9 - step) ? MAX9 : delay_reg + step;
      else
        delay_next = (delay_reg < step) ? 9'h000 : delay_reg - step;
    end
  end

  // controller sequence
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_reg <= dcpdc_pkg::DCPDC_IDLE;
      delay_reg <= 9'h000;
      pass_reg <= 1'b0;
      leg_up_reg <= 1'b0;
      locked_val_reg <= 9'h000;
    end
    else if (!run)
    begin
      state_reg <= dcpdc_pkg::DCPDC_IDLE;
      delay_reg <= setting_clamped;
    end
    else
    begin
      case (state_reg)
        dcpdc_pkg::DCPDC_IDLE:
        begin
          delay_reg <= setting_clamped;
          pass_reg <= (guard == 5'h00);
          leg_up_reg <= first_up;
          if (mode == `DCPDC_MODE_TRACK_ONLY)
            state_reg <= dcpdc_pkg::DCPDC_TRACK;
          else
            state_reg <= dcpdc_pkg::DCPDC_SEARCH;
        end
        dcpdc_pkg::DCPDC_SEARCH:
          if (tick)
          begin
            if (match && delay_reg >= lo && delay_reg <= hi)
            begin
              locked_val_reg <= delay_reg;
              state_reg <= (mode == `DCPDC_MODE_SEARCH_ONLY) ?
                dcpdc_pkg::DCPDC_HOLD : dcpdc_pkg::DCPDC_TRACK;
            end
            else if (leg_up_reg && delay_reg < hi)
              delay_reg <= delay_reg + 9'h001;
            else if (!leg_up_reg && delay_reg > lo)
              delay_reg <= delay_reg - 9'h001;
            else if (!leg_up_reg && dir == `DCPDC_DIR_DOWN_UP)
            begin
              leg_up_reg <= 1'b1;
              delay_reg <= setting_clamped;
            end
            else if (!pass_reg)
            begin
              pass_reg <= 1'b1;
              leg_up_reg <= first_up;
              delay_reg <= setting_clamped;
            end
            else if (policy_reg[`DCPDC_BIT_RETRY])
              state_reg <= dcpdc_pkg::DCPDC_IDLE;
            else if (policy_reg[`DCPDC_BIT_CONTINUE_OR_RESET])
            begin
              delay_reg <= setting_clamped;
              state_reg <= dcpdc_pkg::DCPDC_STOP;
            end
            else if (mode == `DCPDC_MODE_SEARCH_TRACK)
              state_reg <= dcpdc_pkg::DCPDC_TRACK;
            else
              state_reg <= dcpdc_pkg::DCPDC_STOP;
          end
        dcpdc_pkg::DCPDC_TRACK:
          if (tick)
          begin
            delay_reg <= delay_next;
            locked_val_reg <= delay_reg;
          end
        dcpdc_pkg::DCPDC_HOLD: ;
        dcpdc_pkg::DCPDC_STOP: ;
        default: state_reg <= dcpdc_pkg::DCPDC_IDLE;
      endcase
    end
  end

  wire lock_state = (state_reg == dcpdc_pkg::DCPDC_TRACK) ||
    (state_reg == dcpdc_pkg::DCPDC_HOLD);

  // lock and sticky loss
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || !run)
    begin
      locked_reg <= 1'b0;
      lost_reg <= 1'b0;
    end
    else if (tick)
    begin
      locked_reg <= lock_state && phase_ok(phase_in, target, policy_reg[`DCPDC_BIT_TOL]);
      if (locked_reg && !(lock_state && phase_ok(phase_in, target,
          policy_reg[`DCPDC_BIT_TOL])))
        lost_reg <= 1'b1;
    end
  end

  assign delay_line_out = delay_reg;
  assign detector_bias_boost_out = detect_reg[`DCPDC_BIT_BOOST];
  assign detector_auto_enable_out = detect_reg[`DCPDC_BIT_AUTO];
  assign duty_cycle_auto_enable_out = duty_reg[`DCPDC_BIT_DUTY];

  property p_disabled_drive;
    @(posedge mclk_in) disable iff (reset_in)
      !run ##1 !run |-> delay_line_out == $past(setting_clamped);
  endproperty
  a_disabled_drive: assert property (p_disabled_drive)
    else $error("disabled delay line not equal to setting");

  property p_delay_max;
    @(posedge mclk_in) disable iff (reset_in) delay_line_out <= MAX9;
  endproperty
  a_delay_max: assert property (p_delay_max)
    else $error("delay line above maximum");

  property p_lost_sticky;
    @(posedge mclk_in) disable iff (reset_in) lost_reg && run |=> lost_reg;
  endproperty
  a_lost_sticky: assert property (p_lost_sticky)
    else $error("lost lock cleared while enabled");

  property p_lost_clear;
    @(posedge mclk_in) disable iff (reset_in) !run |=> !lost_reg && !locked_reg;
  endproperty
  a_lost_clear: assert property (p_lost_clear)
    else $error("status not cleared when disabled");

  property p_lock_state;
    @(posedge mclk_in) disable iff (reset_in)
      locked_reg |-> $past(lock_state) || lock_state;
  endproperty
  a_lock_state: assert property (p_lock_state)
    else $error("locked outside track or hold");

  property p_search_only;
    @(posedge mclk_in) disable iff (reset_in)
      mode == `DCPDC_MODE_SEARCH_ONLY && state_reg == dcpdc_pkg::DCPDC_SEARCH
      |=> state_reg != dcpdc_pkg::DCPDC_TRACK;
  endproperty
  a_search_only: assert property (p_search_only)
    else $error("search only mode entered tracking");

  property p_track_up;
    @(posedge mclk_in) disable iff (reset_in)
      run && state_reg == dcpdc_pkg::DCPDC_TRACK && tick && slope_pos &&
      phase_in < target && delay_reg <= MAX9 - step
      |=> delay_line_out == $past(delay_reg) + $past(step);
  endproperty
  a_track_up: assert property (p_track_up)
    else $error("tracking step wrong");

  property p_guard_pass;
    @(posedge mclk_in) disable iff (reset_in)
      run && state_reg == dcpdc_pkg::DCPDC_SEARCH && !pass_reg
      && $past(state_reg) == dcpdc_pkg::DCPDC_SEARCH && $past(run)
      && setting_clamped >= lo && setting_clamped <= hi
      |-> delay_line_out >= lo && delay_line_out <= hi;
  endproperty
  a_guard_pass: assert property (p_guard_pass)
    else $error("guarded pass entered guard band");

  property p_status_read;
    @(posedge mclk_in) disable iff (reset_in)
      reg_rd_in && reg_addr_in == `DCPDC_OFF_STATUS
      |=> reg_rdata_out == {6'h00, $past(lost_reg), $past(locked_reg)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status readback wrong");

  property p_delay_read;
    @(posedge mclk_in) disable iff (reset_in)
      reg_rd_in && reg_addr_in == `DCPDC_OFF_DELAY && mode_reg[`DCPDC_BIT_READ]
      && !mode_reg[`DCPDC_BIT_ENABLE] |=> reg_rdata_out == $past(delay_hi_reg);
  endproperty
  a_delay_read: assert property (p_delay_read)
    else $error("delay readback wrong when disabled");

endmodule

/* sim/dcpdc_top_tb.sv */
// Purpose: self-checking bench for the phase delay controller through its register port
// Assumes: settle count shortened to 2 cycles; phase detector modelled from the delay line
// Notes: inputs change on the falling edge; read data sampled a full cycle after the strobe
`timescale 1ns/1ns
`include "dcpdc_map.svh"

module dcpdc_top_tb;
  localparam int SETTLE = 2;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [4:0] phase_in = 5'h0C;
  logic slope_in = 1'b1;
  logic [8:0] delay_line_out;
  logic detector_bias_boost_out;
  logic detector_auto_enable_out;
  logic duty_cycle_auto_enable_out;
  logic jam = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h42, 8'h00, 8'h00, 8'h0B, 8'h00, 8'h00};

  dcpdc_top #(.SETTLE_CYCLES(SETTLE)) dcpdc_top_inst (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .phase_in(phase_in),
    .slope_in(slope_in),
    .delay_line_out(delay_line_out),
    .detector_bias_boost_out(detector_bias_boost_out),
    .detector_auto_enable_out(detector_auto_enable_out),
    .duty_cycle_auto_enable_out(duty_cycle_auto_enable_out)
  );

  always #20 mclk_in = ~mclk_in;

  // detector model: exact target at 210, two steps off at 212, far off elsewhere
  always @(negedge mclk_in)
  begin
    if (jam)
      phase_in <= 5'h0C;
    else if (delay_line_out == 9'd210)
      phase_in <= 5'h04;
    else if (delay_line_out == 9'd212)
      phase_in <= 5'h06;
    else
      phase_in <= 5'h0C;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge mclk_in);
    reg_rd_in = 1'b0;
    @(negedge mclk_in);
    check({1'b0, reg_rdata_out}, {1'b0, exp});
  endtask

  // bounded wait for the delay line to reach a value, then compare it
  task automatic wait_delay(input logic [8:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && delay_line_out !== exp; i++)
      @(negedge mclk_in);
    check(delay_line_out, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #800000;
    fails++;
    conclude();
  end

  initial
  begin
    int k;
    repeat (6) @(negedge mclk_in);
    reset_in = 1'b0;
    for (k = 0; k < 8; k++)
      rd(8'h24 + 8'(k), rst_exp[k]);
    // enables and write masks on the detector and duty registers
    wr(8'h24, 8'hFF);
    wr(8'h25, 8'hFF);
    rd(8'h24, 8'h30);
    rd(8'h25, 8'h01);
    check({6'h00, detector_bias_boost_out, detector_auto_enable_out,
      duty_cycle_auto_enable_out}, 9'h007);
    // disabled: setting drives the line, read bit gates readback
    wr(8'h27, 8'h80);
    wr(8'h28, 8'h6C);
    wr(8'h26, 8'h4A);
    idle(3);
    check(delay_line_out, 9'd217);
    rd(8'h28, 8'h6C);
    wr(8'h26, 8'h42);
    rd(8'h28, 8'h00);
    wr(8'h28, 8'hFF);
    idle(3);
    check(delay_line_out, 9'd432);
    // search only, loose tolerance, downward from 216: stops at 212
    wr(8'h28, 8'h6C);
    wr(8'h27, 8'h04);
    wr(8'h29, 8'h0B);
    wr(8'h26, 8'h5B);
    wait_delay(9'd212, 200);
    idle(12);
    check(delay_line_out, 9'd212);
    rd(8'h2A, 8'h01);
    // search and track, exact tolerance: locks at 210
    wr(8'h26, 8'h4A);
    wr(8'h29, 8'h8B);
    wr(8'h26, 8'h4B);
    wait_delay(9'd210, 200);
    idle(8);
    rd(8'h2A, 8'h01);
    rd(8'h28, 8'h69);
    // detector jammed off target: lock drops and the lost flag sticks
    jam = 1'b1;
    idle(8);
    rd(8'h2A, 8'h02);
    jam = 1'b0;
    idle(20);
    rd(8'h2A, 8'h02);
    wr(8'h26, 8'h4A);
    rd(8'h2A, 8'h00);
    // upward search from 200
    wr(8'h28, 8'h64);
    wr(8'h27, 8'h24);
    wr(8'h26, 8'h4B);
    wait_delay(9'd210, 200);
    // track only from 216: gain 01 steps by two toward the target
    wr(8'h26, 8'h4A);
    wr(8'h28, 8'h6C);
    wr(8'h27, 8'h04);
    wr(8'h26, 8'h6B);
    wait_delay(9'd210, 200);
    idle(8);
    check(delay_line_out, 9'd210);
    // downward from 200 never finds the phase: reset returns to start
    wr(8'h26, 8'h4A);
    wr(8'h28, 8'h64);
    wr(8'h29, 8'hAB);
    wr(8'h26, 8'h4B);
    idle(8);
    check({8'h00, delay_line_out < 9'd200}, 9'h001);
    // the guarded pass ends at the band edge, then the unguarded pass runs down from 200 to 0
    wait_delay(9'd11, 1000);
    wait_delay(9'd0, 1000);
    wait_delay(9'd200, 40);
    idle(8);
    check(delay_line_out, 9'd200);
    rd(8'h2A, 8'h00);
    // track only toward a higher target climbs the line
    wr(8'h26, 8'h4A);
    wr(8'h28, 8'h6C);
    wr(8'h27, 8'h10);
    wr(8'h26, 8'h6B);
    idle(8);
    check({8'h00, delay_line_out > 9'd216}, 9'h001);
    // negative slope wanted, detector reports positive: no lock, search stops at 0
    wr(8'h26, 8'h4A);
    wr(8'h27, 8'h04);
    wr(8'h29, 8'h00);
    wr(8'h26, 8'h1B);
    wait_delay(9'd0, 2000);
    idle(8);
    check(delay_line_out, 9'd0);
    // same search with the detector on the negative slope locks at 212
    wr(8'h26, 8'h4A);
    slope_in = 1'b0;
    wr(8'h26, 8'h1B);
    wait_delay(9'd212, 200);
    idle(8);
    check(delay_line_out, 9'd212);
    conclude();
  end
endmodule
